// ==== tb/hcs_line_model.sv ====
// Purpose: strip, drive and hole detector beside the sequencer
// Assumes: drive moves only while forward or reverse is on
// Notes: a hole opens for four counts at every 32nd count plus 16
`timescale 1ns/100ps
module hcs_line_model #(
   parameter int STEP_GAP = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic fwd_out,
   input wire logic rev_out,
   input wire logic holes_en,
   output logic enc_step,
   output logic enc_fwd,
   output logic hole_in,
   output logic [23:0] pos
);
   int gap;
   // one encoder count every STEP_GAP cycles while the drive runs
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gap <= 0;
         enc_step <= 1'b0;
         enc_fwd <= 1'b1;
         pos <= 24'h0;
      end else begin
         enc_step <= 1'b0;
         if (fwd_out || rev_out) begin
            gap <= (gap == STEP_GAP - 1) ? 0 : gap + 1;
            if (gap == STEP_GAP - 1) begin
               enc_step <= 1'b1;
               enc_fwd <= !rev_out;
               pos <= rev_out ? pos - 24'h1 : pos + 24'h1;
            end
         end
      end
   end
   // detector sees light through the hole window
   assign hole_in = holes_en && pos[4:0] >= 5'h10 && pos[4:0] < 5'h14;
endmodule

// ==== tb/hcs_seq_properties.sv ====
// Purpose: port-level properties of the hole count shear sequencer
// Assumes: one clock, reset asynchronous and active low
// Notes: bound to every sequencer instance at the foot of this file
`timescale 1ns/100ps
module hcs_seq_properties #(
   parameter int SHEAR_CYC = 4
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic order_load,
   input wire logic [13:0] order_qty,
   input wire logic [8:0] hole_count,
   input wire logic prop_analog_cfg,
   input wire logic [11:0] line_fpm,
   input wire logic [10:0] slow_volts,
   input wire logic jog_fwd_key,
   input wire logic jog_rev_key,
   input wire logic shear_out,
   input wire logic fwd_out,
   input wire logic slow_out,
   input wire logic running,
   input wire logic order_reject,
   input wire logic [13:0] qty_left,
   input wire logic no_hole_err,
   input wire logic [10:0] analog_ref
);
   logic [31:0] hi_cnt_ff;
   logic [31:0] nxt_hi_cnt;
   logic jog_f;
   logic act;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // length of the shear pulse so far
   always_comb begin
      nxt_hi_cnt = shear_out ? hi_cnt_ff + 32'h1 : 32'h0;
   end
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hi_cnt_ff <= 32'h0;
      end else begin
         hi_cnt_ff <= nxt_hi_cnt;
      end
   end
   // halted forward jog, and line activity for velocity mode
   assign jog_f = !running && jog_fwd_key && !jog_rev_key && !prop_analog_cfg;
   assign act = prop_analog_cfg && (running || jog_fwd_key || jog_rev_key);
   chk_reject_width: assert property (order_reject && !order_load
      |=> !order_reject) else $error("reject pulse too long");
   chk_qty_range: assert property (order_load && !running &&
      (order_qty == 14'h0 || order_qty > 14'h270F) |=> order_reject)
      else $error("bad quantity taken");
   chk_hole_limit: assert property (order_load && !running &&
      hole_count > 9'h1F4 |=> order_reject) else $error("hole count taken");
   chk_nocount_hold: assert property (running && qty_left == 14'h270F
      |=> qty_left == 14'h270F) else $error("no-count quantity moved");
   chk_run_qty: assert property (running |-> qty_left != 14'h0)
      else $error("running with no pieces left");
   chk_nohole_halt: assert property ($rose(no_hole_err) |-> !running)
      else $error("still running on missing hole");
   chk_shear_width: assert property ($fell(shear_out)
      |-> hi_cnt_ff == SHEAR_CYC) else $error("shear pulse length");
   chk_jog_slow: assert property (jog_f [*4] |-> fwd_out && slow_out
      && analog_ref == slow_volts) else $error("forward jog outputs");
   chk_prop_sat: assert property ((act && line_fpm >= 12'h3E8) [*4]
      |-> analog_ref == 11'h3E8) else $error("velocity level not capped");
   cov_shear: cover property ($rose(shear_out));
   cov_reject: cover property (order_reject);
   cov_nohole: cover property ($rose(no_hole_err));
endmodule
bind hcs_sequencer hcs_seq_properties #(.SHEAR_CYC(SHEAR_CYC))
   hcs_seq_properties_inst (.clock, .rst_b, .order_load, .order_qty,
   .hole_count, .prop_analog_cfg, .line_fpm, .slow_volts, .jog_fwd_key,
   .jog_rev_key, .shear_out, .fwd_out, .slow_out, .running, .order_reject,
   .qty_left, .no_hole_err, .analog_ref);

// ==== tb/tb_hole_count_shear_sequencer.sv ====
// Purpose: self-checking bench for the hole count shear sequencer
// Assumes: short shear pulse of four cycles for simulation
// Notes: cut positions are read from the line model's count
`timescale 1ns/100ps
module tb_hole_count_shear_sequencer;
   localparam int SC = 4;
   logic clock, rst_b, count_hole_mode, remote_run_cfg, prop_analog_cfg;
   logic single_batch, order_load, run_key, remote_run_in, halt_key;
   logic cycle_key, manual_shear_in8, jog_fwd_key, jog_rev_key, holes_en;
   logic enc_step, enc_fwd, hole_in, shear_out, fwd_out, slow_out, rev_out;
   logic running, order_valid, order_reject, no_hole_err, hit;
   logic [13:0] order_qty, qty_left;
   logic [3:0] job_num, job_id;
   logic [8:0] hole_count;
   logic [23:0] offset_len, shear_detect, min_hole_spacing, no_hole_stop;
   logic [23:0] slow_dist, part_len, full_speed_min_length, pos;
   logic [10:0] fast_volts, slow_volts, analog_ref;
   logic [11:0] line_fpm;
   logic [13:0] qt [7] = '{14'h0, 14'h1, 14'h270E, 14'h270F, 14'h2710,
      14'h5, 14'h5};
   logic [8:0] ht [7] = '{9'h1, 9'h1, 9'h1F4, 9'h1, 9'h1, 9'h0, 9'h1F5};
   logic rt [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   int n_errors, check_count, i;
   hcs_sequencer #(.SHEAR_CYC(SC)) hcs_sequencer_inst (.clock, .rst_b,
      .count_hole_mode, .remote_run_cfg, .prop_analog_cfg, .single_batch,
      .order_load, .order_qty, .job_num, .hole_count, .offset_len,
      .shear_detect, .min_hole_spacing, .no_hole_stop, .slow_dist, .part_len,
      .full_speed_min_length, .fast_volts, .slow_volts, .line_fpm, .enc_step,
      .enc_fwd, .hole_in, .run_key, .remote_run_in, .halt_key, .cycle_key,
      .manual_shear_in8, .jog_fwd_key, .jog_rev_key, .shear_out, .fwd_out,
      .slow_out, .rev_out, .running, .order_valid, .order_reject, .qty_left,
      .job_id, .no_hole_err, .analog_ref);
   hcs_line_model hcs_line_model_inst (.clock, .rst_b, .fwd_out, .rev_out,
      .holes_en, .enc_step, .enc_fwd, .hole_in, .pos);
   task automatic chk(input string nm, input logic [23:0] seen,
      input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // bounded wait: 0 shear, 1 running, 2 halted, 3 pos reaches v
   task automatic wait_on(input int sel, input int lim, input int v);
      for (int n = 0; n < lim; n++) begin
         @(negedge clock);
         if ((sel == 0 && shear_out) || (sel == 1 && running) ||
            (sel == 2 && !running) || (sel == 3 && pos == v)) return;
      end
      n_errors++;
      $display("[FAIL] wait %0d expected 1 seen 0", sel);
      give_verdict();
   endtask
   task automatic load(input logic [13:0] q, input logic [8:0] h,
      input logic rej);
      @(posedge clock);
      order_qty <= q;
      hole_count <= h;
      order_load <= 1'b1;
      @(posedge clock);
      order_load <= 1'b0;
      @(negedge clock);
      chk("order_reject", order_reject, rej);
      if (!rej) begin
         chk("qty_left", qty_left, q);
         chk("order_valid", order_valid, 1);
      end
   endtask
   // press: 0 run key, 1 cycle key, 2 input 8; rel lets all go
   task automatic press(input int sel);
      @(posedge clock);
      run_key <= sel == 0;
      cycle_key <= sel == 1;
      manual_shear_in8 <= sel == 2;
   endtask
   task automatic rel();
      @(posedge clock);
      run_key <= 1'b0;
      cycle_key <= 1'b0;
      manual_shear_in8 <= 1'b0;
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      {count_hole_mode, remote_run_cfg, prop_analog_cfg, single_batch,
         order_load, run_key, remote_run_in, halt_key, cycle_key,
         manual_shear_in8, jog_fwd_key, jog_rev_key, holes_en} = '0;
      {order_qty, job_num, hole_count, offset_len, shear_detect,
         min_hole_spacing, no_hole_stop, slow_dist, part_len,
         full_speed_min_length, fast_volts, slow_volts, line_fpm} = '0;
      n_errors = 0;
      check_count = 0;
      rst_b = 1'b0;
      repeat (2) @(posedge clock);
      rst_b <= 1'b1;
      // order limits, then a manual cut on input 8 while halted
      for (i = 0; i < 7; i++) load(qt[i], ht[i], rt[i]);
      press(2);
      wait_on(0, 20, 0);
      rel();
      // two-hole parts, short part scaling and a blocked manual cut
      @(posedge clock);
      count_hole_mode <= 1'b1;
      shear_detect <= 24'hA;
      offset_len <= 24'h5;
      min_hole_spacing <= 24'h8;
      slow_dist <= 24'h4;
      part_len <= 24'h32;
      full_speed_min_length <= 24'h64;
      fast_volts <= 11'h320;
      slow_volts <= 11'h0C8;
      holes_en <= 1'b1;
      job_num <= 4'h3;
      load(14'h2, 9'h2, 1'b0);
      chk("job_id", job_id, 4'h3);
      press(0);
      wait_on(1, 10, 0);
      rel();
      press(1);
      hit = 1'b0;
      repeat (20) @(negedge clock) hit = hit | shear_out;
      rel();
      chk("manual in run", hit, 0);
      wait_on(3, 200, 8);
      repeat (4) @(negedge clock);
      chk("slow_out", slow_out, 1);
      chk("slow level", analog_ref, 11'h0C8);
      wait_on(3, 500, 52);
      repeat (4) @(negedge clock);
      chk("slow_out", slow_out, 0);
      chk("short fast level", analog_ref, 11'h1F4);
      for (i = 0; i < 2; i++) begin
         wait_on(0, 1000, 0);
         chk("cut position", pos, 24'(63 + 64 * i));
         chk("qty_left", qty_left, 24'(1 - i));
         repeat (SC + 2) @(negedge clock);
      end
      chk("running", running, 0);
      // no-count order on the remote contact, single batch unit
      @(posedge clock);
      remote_run_cfg <= 1'b1;
      single_batch <= 1'b1;
      load(14'h270F, 9'h1, 1'b0);
      chk("job_id", job_id, 4'h0);
      @(posedge clock);
      remote_run_in <= 1'b1;
      wait_on(1, 20, 0);
      wait_on(0, 1000, 0);
      repeat (3) @(negedge clock);
      chk("qty_left", qty_left, 14'h270F);
      @(posedge clock);
      remote_run_in <= 1'b0;
      wait_on(2, 20, 0);
      // jog levels, then velocity mode
      @(posedge clock);
      remote_run_cfg <= 1'b0;
      jog_fwd_key <= 1'b1;
      repeat (4) @(negedge clock);
      chk("fwd_out", {fwd_out, slow_out, rev_out}, 3'b110);
      chk("jog level", analog_ref, 11'h0C8);
      @(posedge clock);
      jog_fwd_key <= 1'b0;
      jog_rev_key <= 1'b1;
      prop_analog_cfg <= 1'b1;
      line_fpm <= 12'h5DC;
      repeat (4) @(negedge clock);
      chk("rev_out", {fwd_out, rev_out}, 2'b01);
      chk("capped level", analog_ref, 11'h3E8);
      @(posedge clock);
      line_fpm <= 12'h0FA;
      repeat (4) @(negedge clock);
      chk("speed level", analog_ref, 11'h0FA);
      @(posedge clock);
      jog_rev_key <= 1'b0;
      repeat (4) @(negedge clock);
      chk("idle level", analog_ref, 11'h0);
      // jog over the hole at 176 so a cut at 191 is queued
      @(posedge clock);
      prop_analog_cfg <= 1'b0;
      jog_fwd_key <= 1'b1;
      wait_on(3, 400, 180);
      // clear the queue by two manual cuts, then run with no holes
      @(posedge clock);
      jog_fwd_key <= 1'b0;
      holes_en <= 1'b0;
      no_hole_stop <= 24'h1E;
      for (i = 1; i < 3; i++) begin
         press(i);
         wait_on(0, 20, 0);
         rel();
         repeat (SC + 2) @(posedge clock);
      end
      load(14'h5, 9'h1, 1'b0);
      press(0);
      hit = 1'b0;
      for (i = 0; i < 600 && no_hole_err !== 1'b1; i++) begin
         @(negedge clock);
         hit = hit | shear_out;
      end
      rel();
      chk("no_hole_err", {no_hole_err, running}, 2'b10);
      chk("queued cut", hit, 0);
      chk("qty after clear", qty_left, 14'h5);
      give_verdict();
   end
endmodule

// ==== verilog/hcs_ana_if.sv ====
// Purpose: carrier between sequencer and analog reference generator
// Assumes: single clock domain
// Notes: code is registered inside the generator
`timescale 1ns/100ps
interface hcs_ana_if #(parameter int DW = 24);
   logic run_fast;
   logic run_slow;
   logic jog;
   logic prop_cfg;
   logic [10:0] fast_cv;
   logic [10:0] slow_cv;
   logic [DW-1:0] part_len;
   logic [DW-1:0] full_len;
   logic [11:0] line_fpm;
   logic [10:0] code;
   modport seq (output run_fast, run_slow, jog, prop_cfg, fast_cv,
      slow_cv, part_len, full_len, line_fpm, input code);
   modport ana (input run_fast, run_slow, jog, prop_cfg, fast_cv,
      slow_cv, part_len, full_len, line_fpm, output code);
endinterface

// ==== verilog/hcs_analog.sv ====
// Purpose: 0 to +10 V speed reference code generator
// Assumes: fast setting not below slow setting in normal use
// Notes: one cycle latency from the carrier inputs to code
`timescale 1ns/100ps
module hcs_analog #(
   parameter int DW = 24
) (
   input wire logic clock,
   input wire logic rst_b,
   hcs_ana_if.ana a
);
   logic [10:0] code_ff;
   logic [10:0] nxt_code;
   logic [10:0] diff;
   logic [DW+10:0] prod;
   logic [DW+10:0] scaled;
   logic [10:0] fast_eff;
   logic [10:0] prop_cv;

   // short parts scale the fast level down toward slow
   always_comb begin
      diff = (a.fast_cv > a.slow_cv) ? a.fast_cv - a.slow_cv : 11'h000;
      prod = {{DW{1'b0}}, diff} * {11'h000, a.part_len};
      scaled = (a.full_len != '0) ? prod / {11'h000, a.full_len} : '0;
      fast_eff = a.fast_cv;
      if (a.part_len < a.full_len) begin
         fast_eff = a.slow_cv + scaled[10:0];
      end
   end

   // velocity mode: centivolts equal FPM, clipped at full scale
   always_comb begin
      prop_cv = CV_RST_OR(a.line_fpm);
   end

   function automatic logic [10:0] CV_RST_OR(input logic [11:0] fpm);
      logic [22:0] cv;
      cv = 23'(fpm) * 23'(hcs_pkg::CV_PER_VOLT)
         / 23'(hcs_pkg::FPM_PER_VOLT);
      if (fpm >= hcs_pkg::FPM_SAT) begin
         CV_RST_OR = hcs_pkg::CV_FULL;
      end else begin
         CV_RST_OR = cv[10:0];
      end
   endfunction

   // pick the level for the present motion state
   always_comb begin
      nxt_code = hcs_pkg::CODE_RST;
      if (a.prop_cfg) begin
         if (a.jog || a.run_fast || a.run_slow) begin
            nxt_code = prop_cv;
         end
      end else if (a.jog) begin
         nxt_code = a.slow_cv;
      end else if (a.run_fast) begin
         nxt_code = fast_eff;
      end else if (a.run_slow) begin
         nxt_code = a.slow_cv;
      end
   end

   // zero from reset, inside the 0..10 V span at power up
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         code_ff <= hcs_pkg::CODE_RST;
      end else begin
         code_ff <= nxt_code;
      end
   end

   assign a.code = code_ff;
endmodule

// ==== verilog/hcs_fix_note.sv ====
// Purpose: empty unit, holds no logic
// Assumes: none
// Notes: all sequencer logic lives in the two design modules

// ==== verilog/hcs_pkg.sv ====
// Purpose: shared constants of the hole count shear sequencer
// Assumes: 25 MHz clock; distances in encoder counts
// Notes: analog codes are in hundredths of a volt
package hcs_pkg;
   localparam int CLK_HZ = 25000000;
   // order quantity limits and the no-count value
   localparam logic [13:0] QTY_MIN = 14'h0001;
   localparam logic [13:0] QTY_MAX = 14'h270E;
   localparam logic [13:0] QTY_NOCOUNT = 14'h270F;
   // holes per part limit
   localparam logic [8:0] HOLES_MIN = 9'h001;
   localparam logic [8:0] HOLES_MAX = 9'h1F4;
   // analog scale: centivolts; 1 V per 100 FPM, saturating at 10 V
   localparam logic [10:0] CV_FULL = 11'h3E8;
   localparam int CV_PER_VOLT = 100;
   localparam int FPM_PER_VOLT = 100;
   localparam logic [11:0] FPM_SAT = 12'h3E8;
   // shear press actuation time
   localparam int SHEAR_ON_MS = 100;
   localparam int SHEAR_ON_CYC = SHEAR_ON_MS * (CLK_HZ / 1000);
   // reset values
   localparam logic [13:0] QTY_RST = 14'h0000;
   localparam logic [8:0] HOLES_RST = 9'h001;
   localparam logic [10:0] CODE_RST = 11'h000;
   // run state
   typedef enum logic [0:0] {HCS_HALT, HCS_RUN} hcs_state_e;
endpackage

// ==== verilog/hcs_sequencer.sv ====
// Purpose: hole count shear sequencer with analog speed reference
// Assumes: enc_step is one pulse per count; inputs synchronous
// Notes: positions wrap; compares use signed differences
// Functional notes
// - order quantity 1..9998 accepted, others refused except 9999
// - quantity 9999 never decrements, line never stops on count
// - shear fires when holes for the part reach programmed count
// - programmed holes per part at most 500
// - shear point is offset past leading edge of last counted hole
// - input 8 is an external manual shear request
// - run by panel key, or remote contact when so configured
// - remaining quantity drops per cut, line halts at zero
// - manual shear ignored while running in hole-count mode
// - holes still detected and queued during jogging
// - two manual shears in succession while halted clear the queue
// - after clearing, counting restarts at the first new hole
// - analog reference added, discrete forward and slow kept
// - reference is fast setting in fast, slow setting in slow
// - short parts scale fast-over-slow span by length over full-speed length
// - jog uses slow level; forward/slow or reverse output on
// - velocity mode: 1 V per 100 FPM, 10 V at 1000 FPM and up
// - velocity mode active in jog and run, never negative
// - velocity output may be any level during early power up
// - single-batch units take no job number
// - after a run hole, next hole needs minimum spacing of travel
// - halt with error when past-shear plus shear-detect beyond limit
`timescale 1ns/100ps
module hcs_sequencer #(
   parameter int DW = 24,
   parameter int QDEPTH = 8,
   parameter int SHEAR_CYC = hcs_pkg::SHEAR_ON_CYC
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic count_hole_mode,
   input wire logic remote_run_cfg,
   input wire logic prop_analog_cfg,
   input wire logic single_batch,
   input wire logic order_load,
   input wire logic [13:0] order_qty,
   input wire logic [3:0] job_num,
   input wire logic [8:0] hole_count,
   input wire logic [DW-1:0] offset_len,
   input wire logic [DW-1:0] shear_detect,
   input wire logic [DW-1:0] min_hole_spacing,
   input wire logic [DW-1:0] no_hole_stop,
   input wire logic [DW-1:0] slow_dist,
   input wire logic [DW-1:0] part_len,
   input wire logic [DW-1:0] full_speed_min_length,
   input wire logic [10:0] fast_volts,
   input wire logic [10:0] slow_volts,
   input wire logic [11:0] line_fpm,
   input wire logic enc_step,
   input wire logic enc_fwd,
   input wire logic hole_in,
   input wire logic run_key,
   input wire logic remote_run_in,
   input wire logic halt_key,
   input wire logic cycle_key,
   input wire logic manual_shear_in8,
   input wire logic jog_fwd_key,
   input wire logic jog_rev_key,
   output logic shear_out,
   output logic fwd_out,
   output logic slow_out,
   output logic rev_out,
   output logic running,
   output logic order_valid,
   output logic order_reject,
   output logic [13:0] qty_left,
   output logic [3:0] job_id,
   output logic no_hole_err,
   output logic [10:0] analog_ref
);
   localparam int QW = $clog2(QDEPTH);
   localparam int TW = $clog2(SHEAR_CYC + 1);

   hcs_pkg::hcs_state_e st_ff, nxt_st;
   logic hs1_ff, hs2_ff, hs3_ff;
   logic run_q_ff, cyc_q_ff, in8_q_ff;
   logic [DW-1:0] pos_ff, nxt_pos;
   logic [DW-1:0] blank_ff, nxt_blank;
   logic [DW-1:0] cut_ff, nxt_cut;
   logic [DW-1:0] q_ff [QDEPTH];
   logic [DW-1:0] nxt_q [QDEPTH];
   logic [QW-1:0] rd_ff, nxt_rd, wr_ff, nxt_wr;
   logic [QW:0] qn_ff, nxt_qn;
   logic [8:0] hcnt_ff, nxt_hcnt, per_ff, nxt_per;
   logic [13:0] qty_ff, nxt_qty;
   logic [3:0] job_ff, nxt_job;
   logic valid_ff, nxt_valid, rej_ff, nxt_rej;
   logic man_ff, nxt_man, err_ff, nxt_err;
   logic [TW-1:0] tmr_ff, nxt_tmr;
   logic shear_ff, fwd_ff, slow_ff, rev_ff;
   logic nxt_fwd, nxt_slow, nxt_rev;
   logic hole_edge, run_req, man_req, hole_ok, push, pop, fire;
   logic is_run, due, qty_ok;
   logic [DW-1:0] past, to_go;
   hcs_ana_if #(.DW(DW)) ana ();

   // detector edge and key edges from registered samples
   assign hole_edge = hs2_ff & ~hs3_ff;
   assign run_req = run_key & ~run_q_ff;
   assign man_req = (cycle_key & ~cyc_q_ff)
      | (manual_shear_in8 & ~in8_q_ff);
   assign is_run = (st_ff == hcs_pkg::HCS_RUN);
   assign past = pos_ff - cut_ff;
   assign to_go = q_ff[rd_ff] - pos_ff;
   assign due = (qn_ff != '0) && !to_go[DW-1] && (to_go == '0);
   assign qty_ok = (order_qty >= hcs_pkg::QTY_MIN
      && order_qty <= hcs_pkg::QTY_MAX)
      || order_qty == hcs_pkg::QTY_NOCOUNT;

   // order entry, hole counting, queue, run state and shear timing
   always_comb begin
      nxt_st = st_ff;
      nxt_pos = pos_ff;
      nxt_blank = blank_ff;
      nxt_cut = cut_ff;
      nxt_q = q_ff;
      nxt_rd = rd_ff;
      nxt_wr = wr_ff;
      nxt_qn = qn_ff;
      nxt_hcnt = hcnt_ff;
      nxt_per = per_ff;
      nxt_qty = qty_ff;
      nxt_job = job_ff;
      nxt_valid = valid_ff;
      nxt_rej = 1'b0;
      nxt_man = man_ff;
      nxt_err = err_ff;
      nxt_tmr = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
      push = 1'b0;
      pop = 1'b0;
      fire = 1'b0;
      // encoder position tracks both directions
      if (enc_step) begin
         nxt_pos = enc_fwd ? pos_ff + 1'b1 : pos_ff - 1'b1;
      end
      // order load only while halted
      if (order_load && !is_run) begin
         if (qty_ok && hole_count >= hcs_pkg::HOLES_MIN
               && hole_count <= hcs_pkg::HOLES_MAX) begin
            nxt_qty = order_qty;
            nxt_per = hole_count;
            nxt_valid = 1'b1;
            nxt_job = single_batch ? 4'h0 : job_num;
         end else begin
            nxt_rej = 1'b1;
         end
      end
      // holes are taken in any state, jog included
      hole_ok = hole_edge && (!is_run || !((pos_ff - blank_ff)
         >= (DW'(1) << (DW - 1))));
      if (hole_ok) begin
         nxt_man = 1'b0;
         nxt_blank = pos_ff + min_hole_spacing;
         if (hcnt_ff + 1'b1 >= per_ff) begin
            nxt_hcnt = '0;
            push = (qn_ff != QDEPTH[QW:0]);
         end else begin
            nxt_hcnt = hcnt_ff + 1'b1;
         end
      end
      if (is_run) begin
         // scheduled shear at the queued cut point
         if (count_hole_mode && due) begin
            pop = 1'b1;
            fire = 1'b1;
            nxt_cut = pos_ff;
            if (qty_ff != hcs_pkg::QTY_NOCOUNT) begin
               nxt_qty = qty_ff - 1'b1;
               if (qty_ff == 14'h0001) begin
                  nxt_st = hcs_pkg::HCS_HALT;
               end
            end
         end
         // missing-hole guard
         if (count_hole_mode && no_hole_stop != '0
               && past + shear_detect > no_hole_stop) begin
            nxt_err = 1'b1;
            nxt_st = hcs_pkg::HCS_HALT;
         end
         if (halt_key || (remote_run_cfg && !remote_run_in)) begin
            nxt_st = hcs_pkg::HCS_HALT;
         end
         // standard mode keeps the panel shear while running
         if (man_req && !count_hole_mode) begin
            fire = 1'b1;
            nxt_cut = pos_ff;
         end
      end else begin
         if (valid_ff && qty_ff != '0 && !jog_fwd_key && !jog_rev_key
               && (remote_run_cfg ? remote_run_in : run_req)) begin
            nxt_st = hcs_pkg::HCS_RUN;
            nxt_err = 1'b0;
            nxt_man = 1'b0;
         end else if (man_req) begin
            fire = 1'b1;
            nxt_cut = pos_ff;
            nxt_man = 1'b1;
            if (man_ff) begin
               nxt_man = 1'b0;
               nxt_qn = '0;
               nxt_rd = '0;
               nxt_wr = '0;
               nxt_hcnt = '0;
            end
         end
      end
      // queue bookkeeping after any clear decided above
      if (push && !(man_req && man_ff && !is_run)) begin
         nxt_q[wr_ff] = pos_ff + shear_detect + offset_len;
         nxt_wr = wr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rd = rd_ff + 1'b1;
      end
      if (!(man_req && man_ff && !is_run)) begin
         nxt_qn = qn_ff + (QW + 1)'(push) - (QW + 1)'(pop);
      end
      if (fire) begin
         nxt_tmr = TW'(SHEAR_CYC);
      end
   end

   // discrete drive outputs
   always_comb begin
      nxt_fwd = 1'b0;
      nxt_slow = 1'b0;
      nxt_rev = 1'b0;
      if (nxt_st == hcs_pkg::HCS_RUN) begin
         nxt_fwd = 1'b1;
         nxt_slow = (nxt_qn == '0) || (to_go < slow_dist);
      end else if (jog_fwd_key) begin
         nxt_fwd = 1'b1;
         nxt_slow = 1'b1;
      end else if (jog_rev_key) begin
         nxt_rev = 1'b1;
      end
   end

   // settings handed to the analog generator
   assign ana.run_fast = fwd_ff & ~slow_ff & is_run;
   assign ana.run_slow = slow_ff & is_run;
   assign ana.jog = !is_run && (fwd_ff || rev_ff);
   assign ana.prop_cfg = prop_analog_cfg;
   assign ana.fast_cv = fast_volts;
   assign ana.slow_cv = slow_volts;
   assign ana.part_len = part_len;
   assign ana.full_len = full_speed_min_length;
   assign ana.line_fpm = line_fpm;

   hcs_analog #(.DW(DW)) u_analog (
      .clock(clock),
      .rst_b(rst_b),
      .a(ana)
   );

   // register every state group
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= hcs_pkg::HCS_HALT;
         {hs1_ff, hs2_ff, hs3_ff} <= 3'h0;
         {run_q_ff, cyc_q_ff, in8_q_ff} <= 3'h0;
         pos_ff <= '0;
         blank_ff <= '0;
         cut_ff <= '0;
         q_ff <= '{default: '0};
         rd_ff <= '0;
         wr_ff <= '0;
         qn_ff <= '0;
         hcnt_ff <= '0;
         per_ff <= hcs_pkg::HOLES_RST;
         qty_ff <= hcs_pkg::QTY_RST;
         job_ff <= 4'h0;
         valid_ff <= 1'b0;
         rej_ff <= 1'b0;
         man_ff <= 1'b0;
         err_ff <= 1'b0;
         tmr_ff <= '0;
         {shear_ff, fwd_ff, slow_ff, rev_ff} <= 4'h0;
      end else begin
         st_ff <= nxt_st;
         hs1_ff <= hole_in;
         hs2_ff <= hs1_ff;
         hs3_ff <= hs2_ff;
         run_q_ff <= run_key;
         cyc_q_ff <= cycle_key;
         in8_q_ff <= manual_shear_in8;
         pos_ff <= nxt_pos;
         blank_ff <= nxt_blank;
         cut_ff <= nxt_cut;
         q_ff <= nxt_q;
         rd_ff <= nxt_rd;
         wr_ff <= nxt_wr;
         qn_ff <= nxt_qn;
         hcnt_ff <= nxt_hcnt;
         per_ff <= nxt_per;
         qty_ff <= nxt_qty;
         job_ff <= nxt_job;
         valid_ff <= nxt_valid;
         rej_ff <= nxt_rej;
         man_ff <= nxt_man;
         err_ff <= nxt_err;
         tmr_ff <= nxt_tmr;
         shear_ff <= (nxt_tmr != '0);
         fwd_ff <= nxt_fwd;
         slow_ff <= nxt_slow;
         rev_ff <= nxt_rev;
      end
   end

   // outputs straight from registers
   assign shear_out = shear_ff;
   assign fwd_out = fwd_ff;
   assign slow_out = slow_ff;
   assign rev_out = rev_ff;
   assign running = is_run;
   assign order_valid = valid_ff;
   assign order_reject = rej_ff;
   assign qty_left = qty_ff;
   assign job_id = job_ff;
   assign no_hole_err = err_ff;
   assign analog_ref = ana.code;
endmodule
